// >>> src/cfp_core.sv
// fetch pipeline, program addressing and banked data access
`timescale 1ns/100ps
// What this block does
// - The clock is divided by four into non-overlapping phases one to four per cycle.
// - The program counter steps in phase one and the fetched word is latched in phase four.
// - Each word is fetched in one cycle and executed in the next, one per cycle.
// - The fetched word enters the instruction register in phase one and runs in phases two to four.
// - The data operand is read in phase two and the result written in phase four.
// - A counter-changing instruction discards the prefetched word and so takes two cycles.
// - The program counter is 13 bits, spanning 8K words of 14 bits.
// - Only 4K words exist and higher fetch addresses wrap onto them.
// - Execution starts at 0000h after reset and interrupts enter at 0004h.
// - Each of four banks begins with 32 special registers; banks zero to two follow them with ram.
// - Ram sits at 20h-7Fh, A0h-FFh, 120h-17Fh and 1F0h-1FFh.
// - The top 16 bytes of banks one to three alias common ram at 70h-7Fh.
// - Two status bits choose the bank as a binary number.
// - Any data location is reached directly or through the indirect pointer.
// - Reads of unimplemented data locations give zero.
module cfp_core (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         clk_en,
  // program memory
  output logic [cfp_pkg::IMPL_W-1:0]        prog_addr,
  input  wire logic [cfp_pkg::WORD_W-1:0]   prog_word,
  // interrupt
  input  wire logic                         irq_req,
  output logic                              irq_taken,
  // visible state
  output logic [3:0]                        cycle_phase,
  output logic [cfp_pkg::DATA_W-1:0]        work_value,
  output logic [cfp_pkg::DATA_W-1:0]        status_value
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // 13-bit counter over 8k words
  logic [cfp_pkg::PC_W-1:0]   pc;
  logic [cfp_pkg::WORD_W-1:0] fetch_buf;
  logic                       fetch_valid;
  logic [cfp_pkg::WORD_W-1:0] ir;
  logic                       ir_valid;
  logic [cfp_pkg::DATA_W-1:0] ptr;
  logic [cfp_pkg::DATA_W-1:0] operand;
  logic                       irq_busy;

  cfp_data_if dmem ();

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  cfp_phase_gen u_phase (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .phase   (cycle_phase)
  );

  cfp_data_ram u_ram (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .port    (dmem)
  );

  // ----------------------------------------------------------------
  // phase strobes
  // ----------------------------------------------------------------
  wire step_one  = clk_en & cycle_phase[0];
  wire step_two  = clk_en & cycle_phase[1];
  wire step_four = clk_en & cycle_phase[3];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [1:0] opc      = ir[13:12];
  wire [3:0] fop      = ir[11:8];
  wire       is_file  = ir_valid && (opc == cfp_pkg::OPC_FILE);
  wire       is_jump  = ir_valid && (opc == cfp_pkg::OPC_JUMP);
  wire       is_lit   = ir_valid && (opc == cfp_pkg::OPC_LIT);
  wire       to_file  = ir[cfp_pkg::DEST_BIT];
  wire [1:0] bank     = {status_value[cfp_pkg::BANK_HI_BIT], status_value[cfp_pkg::BANK_LO_BIT]};
  wire [6:0] dir_low  = ir[6:0];
  wire       use_ind  = dir_low == cfp_pkg::ADDR_INDIRECT;
  wire [cfp_pkg::PC_W-1:0] jump_target = {pc[12:11], ir[10:0]};

  // ----------------------------------------------------------------
  // data addressing
  // ----------------------------------------------------------------
  // bank bits above instruction bits
  wire [8:0] dir_addr = {bank, dir_low};
  // pointer path for the indirect slot
  wire [8:0] ind_addr = {bank[1], ptr};
  wire [8:0] eff_addr = use_ind ? ind_addr : dir_addr;
  wire [6:0] eff_low  = eff_addr[6:0];
  // an indirect access through a pointer to the indirect slot finds nothing
  wire       at_ind   = eff_low == cfp_pkg::ADDR_INDIRECT;
  wire       at_pcl   = eff_low == cfp_pkg::ADDR_PCL;
  wire       at_stat  = eff_low == cfp_pkg::ADDR_STATUS;
  wire       at_ptr   = eff_low == cfp_pkg::ADDR_PTR;
  wire       core_sfr = at_pcl | at_stat | at_ptr;

  // core registers mirror in every bank
  // other special slots read as zero
  wire [7:0] core_rd  = at_pcl  ? pc[7:0] :
                        at_stat ? status_value :
                        at_ptr  ? ptr : 8'h00;
  wire [7:0] read_val = at_ind ? 8'h00 : (core_sfr ? core_rd : dmem.rd_data);

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  wire       do_add   = is_file && (fop == cfp_pkg::FOP_ADD);
  wire       do_store = is_file && (fop == cfp_pkg::FOP_STORE);
  wire       do_load  = is_file && (fop == cfp_pkg::FOP_LOAD);
  wire [7:0] sum      = 8'(operand + work_value);
  wire [7:0] result   = do_add ? sum : work_value;
  wire       file_wr  = do_store | (do_add & to_file);
  wire       work_wr  = do_load | is_lit | (do_add & ~to_file);
  wire [7:0] work_in  = is_lit ? ir[7:0] : (do_load ? operand : sum);
  // pcl is kept read-only so file writes never move the counter
  wire       wr_stat  = file_wr && at_stat;
  wire       wr_ptr   = file_wr && at_ptr;
  wire       irq_go   = irq_req && !irq_busy && !is_jump;
  wire       flush    = is_jump | irq_go;

  // ram write strobe only in phase four
  assign dmem.addr    = eff_addr;
  assign dmem.wr_en   = step_four & file_wr & ~core_sfr & ~at_ind;
  assign dmem.wr_data = result;

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // increment in phase one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= cfp_pkg::RESET_VEC;
    end else if (step_one) begin
      pc <= 13'(pc + 13'h0001);
    end else if (step_four && is_jump) begin
      pc <= jump_target;
    end else if (step_four && irq_go) begin
      pc <= cfp_pkg::IRQ_VEC;
    end
  end

  // drop the unbuilt upper half so fetches wrap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_addr <= cfp_pkg::RESET_VEC[cfp_pkg::IMPL_W-1:0];
    end else if (step_one) begin
      prog_addr <= pc[cfp_pkg::IMPL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // fetch and instruction register
  // ----------------------------------------------------------------
  // latch fetched word in phase four
  // a redirect marks the prefetch as discarded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_buf   <= cfp_pkg::WORD_RESET;
      fetch_valid <= 1'b0;
    end else if (step_four) begin
      fetch_buf   <= prog_word;
      fetch_valid <= ~flush;
    end
  end

  // execute what the previous cycle fetched
  // load instruction register in phase one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir       <= cfp_pkg::WORD_RESET;
      ir_valid <= 1'b0;
    end else if (step_one) begin
      ir       <= fetch_buf;
      ir_valid <= fetch_valid;
    end
  end

  // ----------------------------------------------------------------
  // data operand and results
  // ----------------------------------------------------------------
  // operand read in phase two
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      operand <= 8'h00;
    end else if (step_two) begin
      operand <= read_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_value   <= cfp_pkg::WORK_RESET;
      status_value <= cfp_pkg::STATUS_RESET;
      ptr          <= cfp_pkg::PTR_RESET;
    end else if (step_four) begin
      if (work_wr) begin
        work_value <= work_in;
      end
      if (wr_stat) begin
        status_value <= result;
      end
      if (wr_ptr) begin
        ptr <= result;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt entry
  // ----------------------------------------------------------------
  // enter once per request level; a jump in flight goes first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_busy  <= 1'b0;
      irq_taken <= 1'b0;
    end else if (clk_en) begin
      irq_taken <= step_four & irq_go;
      if (step_four && irq_go) begin
        irq_busy <= 1'b1;
      end else if (!irq_req) begin
        irq_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // counter steps by one
  a_pc_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_one |=> pc == 13'($past(pc) + 13'h0001))
    else $error("program counter did not step in phase one");

  a_addr_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_one |=> prog_addr == $past(pc[11:0]))
    else $error("fetch address not wrapped counter");

  a_ir_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_one |=> (ir == $past(fetch_buf)) && (ir_valid == $past(fetch_valid)))
    else $error("instruction register missed prefetch");

  a_jump_flush: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_four && is_jump) |=> !fetch_valid && pc == $past(jump_target))
    else $error("jump did not flush and redirect");

  a_irq_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_four && irq_go) |=> pc == cfp_pkg::IRQ_VEC && irq_taken && !fetch_valid)
    else $error("interrupt did not enter vector");

  // ram writes only in phase four
  a_write_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dmem.wr_en |-> cycle_phase == 4'h8 && clk_en)
    else $error("data write outside phase four");

  a_operand_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    step_two |=> operand == $past(read_val))
    else $error("operand not captured in phase two");

  a_direct_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (is_file && !use_ind)
      |-> dmem.addr == {status_value[6], status_value[5], ir[6:0]})
    else $error("direct address missing bank bits");

  a_irq_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irq_taken && clk_en) |=> !irq_taken)
    else $error("interrupt entry pulse too long");

  a_sfr_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_two && (eff_low < cfp_pkg::SFR_END) && !core_sfr) |=> operand == 8'h00)
    else $error("empty special slot read nonzero");

  a_bank3_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_two && (eff_addr[8:7] == 2'h3) && (eff_low >= cfp_pkg::SFR_END)
      && (eff_low < cfp_pkg::COMMON_LO)) |=> operand == 8'h00)
    else $error("bank three gap read nonzero");

  // results change only on phase four
  a_result_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !step_four |=> $stable(work_value) && $stable(status_value) && $stable(ptr))
    else $error("result written outside phase four");

  a_pc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step_four && !is_jump && !irq_go) |=> pc == $past(pc))
    else $error("counter moved without a jump");

endmodule

// >>> src/cfp_data_if.sv
// data memory port between the core and the banked ram
`timescale 1ns/100ps
interface cfp_data_if;
  logic [cfp_pkg::DADDR_W-1:0] addr;
  logic [cfp_pkg::DATA_W-1:0]  rd_data;
  logic                        wr_en;
  logic [cfp_pkg::DATA_W-1:0]  wr_data;

  modport core (output addr, output wr_en, output wr_data, input rd_data);
  modport ram  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// >>> src/cfp_data_ram.sv
// banked general purpose ram with shared common window
`timescale 1ns/100ps
module cfp_data_ram (
  // clock
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // access port
  cfp_data_if.ram   port
);

  logic [cfp_pkg::DATA_W-1:0] mem [cfp_pkg::GPR_DEPTH];
  wire  [8:0]                 map = cfp_pkg::cfp_gpr_map(port.addr);
  wire                        hit = map[8];
  wire  [7:0]                 idx = map[7:0];

  // ----------------------------------------------------------------
  // read and write
  // ----------------------------------------------------------------
  // unmapped reads give zero
  assign port.rd_data = hit ? mem[idx] : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (port.wr_en && hit) begin
      mem[idx] <= port.wr_data;
    end
  end

  a_common_alias: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port.addr[6:0] >= cfp_pkg::COMMON_LO)
      |-> hit && (idx == 8'(port.addr[6:0] - cfp_pkg::SFR_END)))
    else $error("common window not aliased");

  // bank three holds only the window
  a_bank3_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (port.addr[8:7] == 2'h3 && port.addr[6:0] < cfp_pkg::COMMON_LO) |-> !hit)
    else $error("bank three gap decoded as ram");

endmodule

// >>> src/cfp_phase_gen.sv
// divides the clock into four one-hot instruction phases
`timescale 1ns/100ps
module cfp_phase_gen (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // phases
  output logic [3:0]      phase
);

  cfp_pkg::cfp_phase_e state;
  cfp_pkg::cfp_phase_e next_state;
  logic [3:0]          next_phase;

  // ----------------------------------------------------------------
  // phase sequence
  // ----------------------------------------------------------------
  // divide by four
  always_comb begin
    case (state)
      cfp_pkg::PH_ONE:   next_state = cfp_pkg::PH_TWO;
      cfp_pkg::PH_TWO:   next_state = cfp_pkg::PH_THREE;
      cfp_pkg::PH_THREE: next_state = cfp_pkg::PH_FOUR;
      default:           next_state = cfp_pkg::PH_ONE;
    endcase
    next_phase = 4'h1 << next_state;
  end

  // one-hot kept in flops so the phases never overlap or glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cfp_pkg::PH_ONE;
      phase <= 4'h1;
    end else if (clk_en) begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  a_phase_rotate: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> (phase == {$past(phase[2:0]), $past(phase[3])}) && $onehot(phase))
    else $error("phase did not advance one step");

endmodule

// >>> src/cfp_pkg.sv
// shared constants, encodings and address mapping for the fetch pipeline core
package cfp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PC_W    = 13;
  localparam int IMPL_W  = 12;
  localparam int WORD_W  = 14;
  localparam int DATA_W  = 8;
  localparam int DADDR_W = 9;
  localparam int GPR_DEPTH = 256;

  // ----------------------------------------------------------------
  // vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0]   RESET_VEC    = 13'h0000;
  localparam logic [PC_W-1:0]   IRQ_VEC      = 13'h0004;
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PTR_RESET    = 8'h00;
  localparam logic [DATA_W-1:0] WORK_RESET   = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET   = 14'h0000;

  // ----------------------------------------------------------------
  // data map
  // ----------------------------------------------------------------
  localparam logic [6:0] SFR_END      = 7'h20;
  localparam logic [6:0] COMMON_LO    = 7'h70;
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_PCL     = 7'h02;
  localparam logic [6:0] ADDR_STATUS  = 7'h03;
  localparam logic [6:0] ADDR_PTR     = 7'h04;
  localparam int BANK_HI_BIT = 6;
  localparam int BANK_LO_BIT = 5;
  localparam logic [7:0] BANK1_BASE = 8'h60;
  localparam logic [7:0] BANK2_BASE = 8'hb0;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] OPC_FILE = 2'h0;
  localparam logic [1:0] OPC_JUMP = 2'h2;
  localparam logic [1:0] OPC_LIT  = 2'h3;
  localparam logic [3:0] FOP_STORE = 4'h1;
  localparam logic [3:0] FOP_LOAD  = 4'h2;
  localparam logic [3:0] FOP_ADD   = 4'h3;
  localparam int DEST_BIT = 7;

  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} cfp_phase_e;

  // maps a 9-bit data address to {hit, storage index}
  // special slots hold no ram
  function automatic logic [8:0] cfp_gpr_map(input logic [DADDR_W-1:0] a);
    logic [6:0] low;
    logic [7:0] off;
    low = a[6:0];
    off = {1'b0, low} - {1'b0, SFR_END};
    if (low < SFR_END) begin
      cfp_gpr_map = 9'h000;
    end else if (low >= COMMON_LO) begin
      cfp_gpr_map = {1'b1, off};
    end else begin
      case (a[8:7])
        2'h0:    cfp_gpr_map = {1'b1, off};
        2'h1:    cfp_gpr_map = {1'b1, 8'(off + BANK1_BASE)};
        2'h2:    cfp_gpr_map = {1'b1, 8'(off + BANK2_BASE)};
        default: cfp_gpr_map = 9'h000;
      endcase
    end
  endfunction

endpackage

// >>> tb/cfp_prog_rom.sv
// behavioural program memory model on the core's fetch port
`timescale 1ns/100ps
module cfp_prog_rom (
  // clock
  input  wire logic                       sys_clk,
  // fetch port
  input  wire logic [cfp_pkg::IMPL_W-1:0] prog_addr,
  output logic      [cfp_pkg::WORD_W-1:0] prog_word,
  // answer mode
  input  wire logic                       slow
);
  // ----------------------------------------------------------------
  // storage and access age
  // ----------------------------------------------------------------
  logic [cfp_pkg::WORD_W-1:0] mem [0:4095];
  logic [cfp_pkg::IMPL_W-1:0] last_addr = '0;
  logic                       settled   = 1'b0;
  wire                        moved     = (prog_addr != last_addr);

  // slow mode needs two edges after an address move before the word is good
  always @(posedge sys_clk) begin
    last_addr <= prog_addr;
    settled   <= !moved;
  end

  // no kinder than real memory: an unsettled word shows inverted garbage
  assign prog_word = (slow && (moved || !settled)) ? ~mem[prog_addr] : mem[prog_addr];
endmodule

// >>> tb/cpu_fetch_pipeline_and_memory_map_tb.sv
// self-checking bench for the fetch pipeline core
`timescale 1ns/100ps
module cpu_fetch_pipeline_and_memory_map_tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                       sys_clk;
  logic                       rst_n;
  logic                       clk_en;
  logic                       irq_req;
  logic                       slow;
  logic [cfp_pkg::IMPL_W-1:0] prog_addr;
  logic [cfp_pkg::WORD_W-1:0] prog_word;
  logic                       irq_taken;
  logic [3:0]                 cycle_phase;
  logic [cfp_pkg::DATA_W-1:0] work_value;
  logic [cfp_pkg::DATA_W-1:0] status_value;
  int                         bad_count;
  int                         checked;
  int                         edges;

  cfp_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .prog_addr(prog_addr),
    .prog_word(prog_word), .irq_req(irq_req), .irq_taken(irq_taken),
    .cycle_phase(cycle_phase), .work_value(work_value), .status_value(status_value));
  cfp_prog_rom rom (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_word(prog_word),
    .slow(slow));

  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // instruction words and helpers
  // ----------------------------------------------------------------
  function automatic logic [13:0] i_lit(input logic [7:0] v);
    return {cfp_pkg::OPC_LIT, 4'h0, v};
  endfunction
  function automatic logic [13:0] i_st(input logic [6:0] a);
    return {cfp_pkg::OPC_FILE, cfp_pkg::FOP_STORE, 1'b1, a};
  endfunction
  function automatic logic [13:0] i_ld(input logic [6:0] a);
    return {cfp_pkg::OPC_FILE, cfp_pkg::FOP_LOAD, 1'b0, a};
  endfunction
  function automatic logic [13:0] i_add(input logic [6:0] a);
    return {cfp_pkg::OPC_FILE, cfp_pkg::FOP_ADD, 1'b0, a};
  endfunction
  function automatic logic [13:0] i_jump(input logic [10:0] t);
    return {cfp_pkg::OPC_JUMP, 1'b0, t};
  endfunction

  // steps n rising edges, landing on the falling edge for driving
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    edges += n;
  endtask

  // advance until instruction i (no jumps before it) has written back
  task automatic run_to(input int i);
    tick(4 * (i + 2) - edges);
  endtask

  // reset with a rom full of nops, held for 20 cycles
  task automatic do_reset(input logic slow_mode);
    int i;
    rst_n   = 1'b0;
    irq_req = 1'b0;
    slow    = slow_mode;
    for (i = 0; i < 4096; i++) rom.mem[i] = 14'h1000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    edges = 0;
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, phase rotation, fetch and write-back timing, freeze
  task automatic t_reset_phases();
    int k;
    logic [3:0] ph;
    do_reset(1'b0);
    rom.mem[0] = i_lit(8'h5a);
    cmp_val({12'h000, cycle_phase}, 16'h0001);
    cmp_val({4'h0, prog_addr}, 16'h0000);
    cmp_val({8'h00, status_value}, 16'h0000);
    ph = 4'b0001;
    for (k = 1; k <= 8; k++) begin
      tick(1);
      ph = {ph[2:0], ph[3]};
      cmp_val({12'h000, cycle_phase}, {12'h000, ph});
      if (k == 4) cmp_val({4'h0, prog_addr}, 16'h0000);
      if (k == 5) cmp_val({4'h0, prog_addr}, 16'h0001);
      if (k == 7) cmp_val({8'h00, work_value}, 16'h0000);
    end
    cmp_val({8'h00, work_value}, 16'h005a);
    // a low enable must hold the phase still
    clk_en = 1'b0;
    repeat (5) @(negedge sys_clk);
    cmp_val({12'h000, cycle_phase}, 16'h0001);
    clk_en = 1'b1;
  endtask

  // banks, common window, unimplemented reads, indirect access
  task automatic t_data_map();
    int k;
    logic [13:0] p [32];
    p = '{i_lit(8'h11), i_st(7'h20), i_lit(8'h60), i_st(7'h03), i_lit(8'h77),
          i_st(7'h75), i_ld(7'h20), i_lit(8'h00), i_st(7'h03), i_ld(7'h75),
          i_ld(7'h20), i_lit(8'ha0), i_st(7'h04), i_lit(8'h33), i_st(7'h00),
          i_lit(8'h20), i_st(7'h03), i_ld(7'h20), i_add(7'h20), i_ld(7'h03),
          i_ld(7'h05), i_lit(8'h40), i_st(7'h03), i_lit(8'h5c), i_st(7'h20),
          i_ld(7'h75), i_ld(7'h20), i_lit(8'h00), i_st(7'h03), i_ld(7'h20),
          {cfp_pkg::OPC_FILE, cfp_pkg::FOP_ADD, 1'b1, 7'h20}, i_ld(7'h20)};
    do_reset(1'b0);
    for (k = 0; k < 32; k++) rom.mem[k] = p[k];
    run_to(6);
    cmp_val({8'h00, work_value}, 16'h0000);
    run_to(9);
    cmp_val({8'h00, work_value}, 16'h0077);
    run_to(10);
    cmp_val({8'h00, work_value}, 16'h0011);
    run_to(17);
    cmp_val({8'h00, work_value}, 16'h0033);
    run_to(18);
    cmp_val({8'h00, work_value}, 16'h0066);
    run_to(19);
    cmp_val({8'h00, work_value}, 16'h0020);
    cmp_val({8'h00, status_value}, 16'h0020);
    run_to(20);
    cmp_val({8'h00, work_value}, 16'h0000);
    // bank two storage, its common window, and add back into a file
    run_to(22);
    cmp_val({8'h00, status_value}, 16'h0040);
    run_to(25);
    cmp_val({8'h00, work_value}, 16'h0077);
    run_to(26);
    cmp_val({8'h00, work_value}, 16'h005c);
    run_to(29);
    cmp_val({8'h00, work_value}, 16'h0011);
    run_to(30);
    cmp_val({8'h00, work_value}, 16'h0011);
    run_to(31);
    cmp_val({8'h00, work_value}, 16'h0022);
  endtask

  // jump flushes the prefetch; the fetch address wraps onto the 4k space
  task automatic t_jump_wrap();
    do_reset(1'b0);
    rom.mem[0] = i_jump(11'h7fe);
    rom.mem[1] = i_lit(8'h99);
    rom.mem[12'h7fe] = i_lit(8'h42);
    tick(8);
    cmp_val({4'h0, prog_addr}, 16'h0001);
    tick(4);
    cmp_val({4'h0, prog_addr}, 16'h07fe);
    cmp_val({8'h00, work_value}, 16'h0000);
    tick(4);
    cmp_val({8'h00, work_value}, 16'h0042);
    tick(4 * (16'h804 - 4));
    cmp_val({4'h0, prog_addr}, 16'h0fff);
    tick(4);
    cmp_val({4'h0, prog_addr}, 16'h0000);
    tick(8);
    cmp_val({4'h0, prog_addr}, 16'h07fe);
  endtask

  // interrupt entry to the vector with a slow memory
  task automatic t_irq();
    int k;
    do_reset(1'b1);
    rom.mem[0] = i_jump(11'h010);
    tick(24);
    irq_req = 1'b1;
    for (k = 0; k < 12 && irq_taken !== 1'b1; k++) tick(1);
    cmp_flag(irq_taken, 1'b1);
    for (k = 0; k < 8 && cycle_phase !== 4'b0010; k++) tick(1);
    cmp_val({4'h0, prog_addr}, 16'h0004);
    tick(1);
    cmp_flag(irq_taken, 1'b0);
    irq_req = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // tests need about 8500 cycles; 20000 means a hang
  initial begin
    #(20000 * 25);
    bad_count++;
    give_verdict();
  end

  initial begin
    sys_clk   = 1'b0;
    rst_n     = 1'b0;
    clk_en    = 1'b1;
    irq_req   = 1'b0;
    slow      = 1'b0;
    bad_count = 0;
    checked   = 0;
    edges     = 0;
    t_reset_phases();
    t_data_map();
    t_jump_wrap();
    t_irq();
    give_verdict();
  end
endmodule
